// ===== pmux_top.sv
// top of the pin mux: pad lines, identifier decode, address window decode
`default_nettype none

module pmux_top (
    // clock and reset
    input  wire logic         CORE_CLK_I,
    input  wire logic         EXTERNAL_RESET_PIN_I,
    // per-line controls from the port controllers, port n at bits 32n+31:32n
    input  wire logic [127:0] MODE_SET_I,
    input  wire logic [127:0] MODE_CLR_I,
    input  wire logic [127:0] PULL_SET_I,
    input  wire logic [127:0] PULL_CLR_I,
    input  wire logic [127:0] SEL_B_I,
    input  wire logic [127:0] GPIO_OUT_I,
    input  wire logic [127:0] GPIO_OE_I,
    // peripheral function drive
    input  wire logic [127:0] FUNC_A_OUT_I,
    input  wire logic [127:0] FUNC_A_OE_I,
    input  wire logic [127:0] FUNC_B_OUT_I,
    input  wire logic [127:0] FUNC_B_OE_I,
    // pad side
    output logic      [127:0] PAD_OUT_O,
    output logic      [127:0] PAD_OE_O,
    output logic      [127:0] PAD_PULL_O,
    output logic      [127:0] PERIPH_MODE_STATUS_O,
    output logic              WIDE_BUS_OK_O,
    // identifier decode
    input  wire logic [4:0]   PID_I,
    input  wire logic         PID_VLD_I,
    output logic      [31:0]  IRQ_SRC_SEL_O,
    output logic      [31:0]  CLK_EN_SEL_O,
    output logic      [3:0]   PID_PORT_O,
    output logic      [2:0]   PID_SSC_O,
    output logic      [6:0]   PID_EIRQ_O,
    // address window decode
    input  wire logic [31:0]  ADDR_I,
    output logic              ADDR_HIT_O,
    output logic      [4:0]   ADDR_SLOT_O
);
    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops, assertion is immediate
    logic rst_meta_q;   // first stage, read only by second
    logic rst_n_q;      // released reset for the block

    always_ff @(posedge CORE_CLK_I or negedge EXTERNAL_RESET_PIN_I) begin
        if (!EXTERNAL_RESET_PIN_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad lines, one instance per line of each port
    logic [127:0] mode_w;   // peripheral status of all lines

    for (genvar g = 0; g < pmux_pkg::NPORT * pmux_pkg::NLINE; g++) begin : g_line
        pmux_line #(
            .RESET_PERIPH (pmux_pkg::RST_PERIPH[g]),
            .HAS_FUNC_B   (pmux_pkg::HAS_B[g])
        ) u_line (
            .clk_i      (CORE_CLK_I),
            .rst_n_i    (rst_n_q),
            .mode_set_i (MODE_SET_I[g]),
            .mode_clr_i (MODE_CLR_I[g]),
            .pull_set_i (PULL_SET_I[g]),
            .pull_clr_i (PULL_CLR_I[g]),
            .sel_b_i    (SEL_B_I[g]),
            .gpio_out_i (GPIO_OUT_I[g]),
            .gpio_oe_i  (GPIO_OE_I[g]),
            .a_out_i    (FUNC_A_OUT_I[g]),
            .a_oe_i     (FUNC_A_OE_I[g]),
            .b_out_i    (FUNC_B_OUT_I[g]),
            .b_oe_i     (FUNC_B_OE_I[g]),
            .pad_out_o  (PAD_OUT_O[g]),
            .pad_oe_o   (PAD_OE_O[g]),
            .pull_o     (PAD_PULL_O[g]),
            .mode_o     (mode_w[g])
        );
    end

    assign PERIPH_MODE_STATUS_O = mode_w;

    ////////////////////////////////////////////////////////////////////////////
    // wide bus availability of the third port
    logic wide_q, wide_d;   // high while all upper data lines are peripheral

    // upper data lines as pads block 32-bit
    always_comb begin
        wide_d = &mode_w[pmux_pkg::PORT_THIRD * pmux_pkg::NLINE + pmux_pkg::WIDE_LO +:
                         pmux_pkg::WIDE_LO];
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wide_q <= 1'b0;
        end else begin
            wide_q <= wide_d;
        end
    end

    assign WIDE_BUS_OK_O = wide_q;

    ////////////////////////////////////////////////////////////////////////////
    // identifier decode
    logic [31:0] sel_q, sel_d;     // one-hot selection
    logic [3:0]  port_q, port_d;   // port controller class
    logic [2:0]  ssc_q, ssc_d;     // serial controller class
    logic [6:0]  eirq_q, eirq_d;   // external interrupt class

    always_comb begin
        sel_d  = 32'h00000000;
        port_d = 4'h0;
        ssc_d  = 3'h0;
        eirq_d = 7'h00;
        if (PID_VLD_I) begin
            // same one-hot for interrupt and clock
            sel_d = 32'h00000001 << PID_I;
            if (PID_I >= pmux_pkg::PID_PORT_LO && PID_I <= pmux_pkg::PID_PORT_HI) begin
                port_d = 4'h1 << 2'(PID_I - pmux_pkg::PID_PORT_LO);
            end
            if (PID_I >= pmux_pkg::PID_SSC_LO && PID_I <= pmux_pkg::PID_SSC_HI) begin
                ssc_d = 3'h1 << 2'(PID_I - pmux_pkg::PID_SSC_LO);
            end
            if (PID_I >= pmux_pkg::PID_EIRQ_LO) begin
                eirq_d = 7'h01 << 3'(PID_I - pmux_pkg::PID_EIRQ_LO);
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sel_q  <= 32'h00000000;
            port_q <= 4'h0;
            ssc_q  <= 3'h0;
            eirq_q <= 7'h00;
        end else begin
            sel_q  <= sel_d;
            port_q <= port_d;
            ssc_q  <= ssc_d;
            eirq_q <= eirq_d;
        end
    end

    assign IRQ_SRC_SEL_O = sel_q;
    assign CLK_EN_SEL_O  = sel_q;
    assign PID_PORT_O    = port_q;
    assign PID_SSC_O     = ssc_q;
    assign PID_EIRQ_O    = eirq_q;

    ////////////////////////////////////////////////////////////////////////////
    // address window decode
    logic        hit_q, hit_d;     // address inside the window
    logic [4:0]  slot_q, slot_d;   // 16-Kbyte slot index
    logic [31:0] offs;             // offset from window base

    always_comb begin
        offs   = ADDR_I - pmux_pkg::PERIPH_BASE;
        hit_d  = (ADDR_I >= pmux_pkg::PERIPH_BASE) && (ADDR_I <= pmux_pkg::PERIPH_LAST);
        slot_d = hit_d ? offs[pmux_pkg::SLOT_SHIFT +: pmux_pkg::SLOT_W] : 5'h00;
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hit_q  <= 1'b0;
            slot_q <= 5'h00;
        end else begin
            hit_q  <= hit_d;
            slot_q <= slot_d;
        end
    end

    assign ADDR_HIT_O  = hit_q;
    assign ADDR_SLOT_O = slot_q;
endmodule

`default_nettype wire

// ===== pmux_line.sv
// package of pin mux constants and the single pad line multiplexer
`default_nettype none

package pmux_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // address window
    localparam logic [31:0] PERIPH_BASE   = 32'hFFFA0000;
    localparam logic [31:0] PERIPH_LAST   = 32'hFFFE3FFF;
    localparam int          SLOT_SHIFT    = 14;           // 16-Kbyte slots
    localparam int          SLOT_W        = 5;
    ////////////////////////////////////////////////////////////////////////////
    // peripheral identifiers
    localparam int          PID_W         = 5;
    localparam logic [4:0]  PID_PORT_LO   = 5'h02;
    localparam logic [4:0]  PID_PORT_HI   = 5'h05;
    localparam logic [4:0]  PID_SSC_LO    = 5'h0E;
    localparam logic [4:0]  PID_SSC_HI    = 5'h10;
    localparam logic [4:0]  PID_EIRQ_LO   = 5'h19;
    localparam logic [4:0]  PID_EIRQ_HI   = 5'h1F;
    ////////////////////////////////////////////////////////////////////////////
    // port layout
    localparam int          NPORT         = 4;
    localparam int          NLINE         = 32;
    localparam int          PORT_THIRD    = 2;
    localparam int          WIDE_LO       = 16;           // upper data bus lines
    // lines that come out of reset in peripheral mode
    localparam logic [31:0] RST_PERIPH_A  = 32'h00000000;
    localparam logic [31:0] RST_PERIPH_B  = 32'h00000000;
    localparam logic [31:0] RST_PERIPH_C  = 32'h00003F80;
    localparam logic [31:0] RST_PERIPH_D  = 32'h00000000;
    // lines that own a function B
    localparam logic [31:0] HAS_B_A       = 32'hFFFFFFFF;
    localparam logic [31:0] HAS_B_B       = 32'h020FFFFF;
    localparam logic [31:0] HAS_B_C       = 32'h00000000;
    localparam logic [31:0] HAS_B_D       = 32'h00000180;
    localparam logic [127:0] RST_PERIPH   = {RST_PERIPH_D, RST_PERIPH_C,
                                             RST_PERIPH_B, RST_PERIPH_A};
    localparam logic [127:0] HAS_B        = {HAS_B_D, HAS_B_C, HAS_B_B, HAS_B_A};
    // reset values of per-line state
    localparam logic        PULL_RST      = 1'h1;
endpackage

////////////////////////////////////////////////////////////////////////////////
// one pad line: mode and pull-up state plus output mux
module pmux_line #(
    parameter logic RESET_PERIPH = 1'b0,    // line resets in peripheral mode
    parameter logic HAS_FUNC_B   = 1'b1     // function B exists on this line
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // mode and pull-up strobes
    input  wire logic mode_set_i,
    input  wire logic mode_clr_i,
    input  wire logic pull_set_i,
    input  wire logic pull_clr_i,
    input  wire logic sel_b_i,
    // general purpose drive
    input  wire logic gpio_out_i,
    input  wire logic gpio_oe_i,
    // peripheral drive
    input  wire logic a_out_i,
    input  wire logic a_oe_i,
    input  wire logic b_out_i,
    input  wire logic b_oe_i,
    // pad side
    output logic      pad_out_o,
    output logic      pad_oe_o,
    output logic      pull_o,
    output logic      mode_o
);
    logic mode_q, mode_d;   // peripheral status
    logic pull_q, pull_d;   // pull-up enable
    logic out_q, out_d;     // pad level
    logic oe_q, oe_d;       // pad drive enable

    // next state of mode, pull-up and pad drive
    always_comb begin
        mode_d = mode_q;
        if (mode_set_i) begin
            mode_d = 1'b1;
        end else if (mode_clr_i) begin
            mode_d = 1'b0;
        end
        pull_d = pull_q;
        if (pull_set_i) begin
            pull_d = 1'b1;
        end else if (pull_clr_i) begin
            pull_d = 1'b0;
        end
        if (!mode_q) begin
            out_d = gpio_out_i;
            oe_d  = gpio_oe_i;
        end else if (!sel_b_i) begin
            out_d = a_out_i;
            oe_d  = a_oe_i;
        end else if (HAS_FUNC_B) begin
            out_d = b_out_i;
            oe_d  = b_oe_i;
        end else begin
            out_d = 1'b0;
            oe_d  = 1'b0;
        end
    end

    // state registers, reset acts at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= RESET_PERIPH;
            pull_q <= pmux_pkg::PULL_RST;
            out_q  <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            mode_q <= mode_d;
            pull_q <= pull_d;
            out_q  <= out_d;
            oe_q   <= oe_d;
        end
    end

    assign pad_out_o = out_q;
    assign pad_oe_o  = oe_q;
    assign pull_o    = pull_q;
    assign mode_o    = mode_q;
endmodule

`default_nettype wire

// ===== pmux_periph_model.sv
// peripheral function drivers standing beside the pin mux
`default_nettype none
module pmux_periph_model (
    // clock and drive enable
    input  wire logic         clk_i,
    input  wire logic         en_i,
    // function A and B drive
    output logic      [127:0] a_out_o,
    output logic      [127:0] a_oe_o,
    output logic      [127:0] b_out_o,
    output logic      [127:0] b_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] pat_q = {4{32'h5A3C96E1}}; // running pattern
    // new value every cycle so a stale pad value never matches
    always @(negedge clk_i) pat_q <= {pat_q[126:0], pat_q[127] ^ pat_q[93]};
    assign a_out_o = pat_q;
    assign b_out_o = ~{pat_q[63:0], pat_q[127:64]};
    // function A enables move with the pattern so function A and port drive differ
    assign a_oe_o  = {128{en_i}} & {pat_q[31:0], pat_q[127:32]};
    assign b_oe_o  = {64{en_i, 1'b0}};
endmodule
`default_nettype wire

// ===== pmux_top_chk_assertions.sv
// checker of port relations of the pin mux top
`default_nettype none
module pmux_top_chk (
    input wire logic         CORE_CLK_I,
    input wire logic         EXTERNAL_RESET_PIN_I,
    input wire logic [127:0] MODE_SET_I,
    input wire logic [127:0] SEL_B_I,
    input wire logic [127:0] GPIO_OE_I,
    input wire logic [127:0] FUNC_A_OE_I,
    input wire logic [127:0] FUNC_B_OE_I,
    input wire logic [127:0] PAD_OE_O,
    input wire logic [127:0] PERIPH_MODE_STATUS_O,
    input wire logic [4:0]   PID_I,
    input wire logic         PID_VLD_I,
    input wire logic [31:0]  IRQ_SRC_SEL_O,
    input wire logic [31:0]  CLK_EN_SEL_O,
    input wire logic [3:0]   PID_PORT_O,
    input wire logic [2:0]   PID_SSC_O,
    input wire logic [31:0]  ADDR_I,
    input wire logic         ADDR_HIT_O,
    input wire logic [4:0]   ADDR_SLOT_O
);
    logic [1:0]  cnt_q; // edges since reset release
    logic [4:0]  p_q;   // last identifier
    logic        v_q;   // last identifier valid
    logic [31:0] a_q;   // last address
    // decode needs three edges after release before it answers
    always_ff @(posedge CORE_CLK_I or negedge EXTERNAL_RESET_PIN_I)
        if (!EXTERNAL_RESET_PIN_I) cnt_q <= 2'h0;
        else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
    always_ff @(posedge CORE_CLK_I) begin
        p_q <= PID_I;
        v_q <= PID_VLD_I;
        a_q <= ADDR_I;
    end
    wire logic ok  = cnt_q == 2'h3;
    wire logic hit = a_q >= 32'hFFFA0000 && a_q <= 32'hFFFE3FFF;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!EXTERNAL_RESET_PIN_I);
    irq_onehot_a:
        assert property (ok |-> IRQ_SRC_SEL_O == (v_q ? 32'h1 << p_q : 32'h0))
        else $error("interrupt select wrong");
    irq_clk_same_a:
        assert property (IRQ_SRC_SEL_O == CLK_EN_SEL_O) else $error("clock select differs");
    port_id_a:
        assert property (ok |-> PID_PORT_O == ((v_q && p_q inside {[5'h02:5'h05]}) ?
            4'h1 << (p_q - 5'h02) : 4'h0)) else $error("port id wrong");
    ssc_id_a:
        assert property (ok |-> PID_SSC_O == ((v_q && p_q inside {[5'h0E:5'h10]}) ?
            3'h1 << (p_q - 5'h0E) : 3'h0)) else $error("serial id wrong");
    addr_hit_a:
        assert property (ok |-> ADDR_HIT_O == hit) else $error("window hit wrong");
    addr_slot_a:
        assert property (ok |-> ADDR_SLOT_O == (hit ? 5'((a_q - 32'hFFFA0000) >> 14) : 5'h0))
        else $error("slot wrong");
    mode_set_a:
        assert property (ok |-> (PERIPH_MODE_STATUS_O & $past(MODE_SET_I)) == $past(MODE_SET_I))
        else $error("mode not set");
    pad_src_a:
        assert property (ok |-> PAD_OE_O[0] == ($past(PERIPH_MODE_STATUS_O[0]) ?
            ($past(SEL_B_I[0]) ? $past(FUNC_B_OE_I[0]) : $past(FUNC_A_OE_I[0])) :
            $past(GPIO_OE_I[0]))) else $error("pad source wrong");
    no_func_b_a:
        assert property ($past(PERIPH_MODE_STATUS_O[81]) && $past(SEL_B_I[81]) |->
            !PAD_OE_O[81]) else $error("missing function drives pad");
endmodule
bind pmux_top pmux_top_chk i_chk (.CORE_CLK_I, .EXTERNAL_RESET_PIN_I, .MODE_SET_I, .SEL_B_I, .GPIO_OE_I,
    .FUNC_A_OE_I, .FUNC_B_OE_I, .PAD_OE_O, .PERIPH_MODE_STATUS_O, .PID_I, .PID_VLD_I,
    .IRQ_SRC_SEL_O, .CLK_EN_SEL_O, .PID_PORT_O, .PID_SSC_O, .ADDR_I, .ADDR_HIT_O, .ADDR_SLOT_O);
`default_nettype wire

// ===== peripheral_pin_mux_and_ids_tb.sv
// self-checking bench of the pin mux top
`default_nettype none
module peripheral_pin_mux_and_ids_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk, external_reset_pin, vld, en, hit, wide;
    logic [127:0] ms, mc, ps, pc, sb, go, ge, fa, fb, fao, fbo, po, poe, pl, st;
    logic [127:0] a_q, b_q, ao_q, bo_q, exp_st, exp_pl;
    logic [31:0]  irq, cke, addr;
    logic [4:0]   pid, slot;
    logic [3:0]   pport;
    logic [2:0]   pssc;
    logic [6:0]   peirq;
    int           miscompares = 0;
    int           tests_run = 0;
    pmux_top i_dut (.CORE_CLK_I(clk), .EXTERNAL_RESET_PIN_I(external_reset_pin), .MODE_SET_I(ms), .MODE_CLR_I(mc),
        .PULL_SET_I(ps), .PULL_CLR_I(pc), .SEL_B_I(sb), .GPIO_OUT_I(go), .GPIO_OE_I(ge),
        .FUNC_A_OUT_I(fa), .FUNC_A_OE_I(fao), .FUNC_B_OUT_I(fb), .FUNC_B_OE_I(fbo),
        .PAD_OUT_O(po), .PAD_OE_O(poe), .PAD_PULL_O(pl), .PERIPH_MODE_STATUS_O(st),
        .WIDE_BUS_OK_O(wide), .PID_I(pid), .PID_VLD_I(vld), .IRQ_SRC_SEL_O(irq),
        .CLK_EN_SEL_O(cke), .PID_PORT_O(pport), .PID_SSC_O(pssc), .PID_EIRQ_O(peirq),
        .ADDR_I(addr), .ADDR_HIT_O(hit), .ADDR_SLOT_O(slot));
    pmux_periph_model i_model (.clk_i(clk), .en_i(en), .a_out_o(fa), .a_oe_o(fao),
        .b_out_o(fb), .b_oe_o(fbo));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // function drive as the design sampled it
    always @(posedge clk) begin
        a_q  <= fa;
        b_q  <= fb;
        ao_q <= fao;
        bo_q <= fbo;
    end
    task automatic chk(input logic [127:0] s, input logic [127:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // pad side against the tracked line state
    task automatic pads();
        chk(st, exp_st);
        chk(pl, exp_pl);
        chk(po, (exp_st & ~sb & a_q) | (exp_st & sb & pmux_pkg::HAS_B & b_q) | (~exp_st & go));
        chk(poe, (exp_st & ~sb & ao_q) | (exp_st & sb & pmux_pkg::HAS_B & bo_q) | (~exp_st & ge));
        chk(wide, &exp_st[95:80]);
    endtask
    task automatic apply(input logic [127:0] s, c, p, q, b);
        @(negedge clk);
        {ms, mc, ps, pc, sb} = {s, c, p, q, b};
        go = ~go;
        ge = go ^ {4{32'hF0F0F0F0}};
        repeat (3) @(negedge clk);
        exp_st = (exp_st & ~c) | s;
        exp_pl = (exp_pl & ~q) | p;
        {ms, mc, ps, pc} = '0;
        pads();
    endtask
    task automatic do_reset();
        @(negedge clk);
        external_reset_pin = 1'b0;
        en = ~en;
        #1;
        chk(pl, '1);
        chk(st & ~pmux_pkg::RST_PERIPH, '0);
        chk(poe, '0);
        chk(st, pmux_pkg::RST_PERIPH);
        repeat (20) @(negedge clk);
        external_reset_pin = 1'b1;
        exp_st = pmux_pkg::RST_PERIPH;
        exp_pl = '1;
        repeat (4) @(negedge clk);
        pads();
    endtask
    task automatic ids();
        for (int i = 0; i < 33; i++) begin
            @(negedge clk);
            pid = 5'(i);
            vld = i < 32;
            @(negedge clk);
            chk(irq, vld ? 128'h1 << i : 128'h0);
            chk(cke, vld ? 128'h1 << i : 128'h0);
            chk(pport, (vld && i >= 2 && i <= 5) ? 128'h1 << (i - 2) : 128'h0);
            chk(pssc, (vld && i >= 14 && i <= 16) ? 128'h1 << (i - 14) : 128'h0);
            chk(peirq, (vld && i >= 25) ? 128'h1 << (i - 25) : 128'h0);
        end
    endtask
    task automatic addrs();
        logic [31:0] t [6] = '{32'hFFF9FFFF, 32'hFFFA0000, 32'hFFFA4000, 32'hFFFE3FFF,
                               32'hFFFE4000, 32'h0};
        logic h;
        foreach (t[k]) begin
            @(negedge clk);
            addr = t[k];
            @(negedge clk);
            h = t[k] >= pmux_pkg::PERIPH_BASE && t[k] <= pmux_pkg::PERIPH_LAST;
            chk(hit, h);
            chk(slot, h ? (t[k] - pmux_pkg::PERIPH_BASE) >> 14 : 128'h0);
        end
    endtask
    initial begin
        {external_reset_pin, en, vld, pid, addr} = {1'b0, 1'b0, 1'b0, 5'h00, 32'h0};
        {ms, mc, ps, pc, sb, ge} = '0;
        go = {4{32'h3C5A0F96}};
        do_reset();
        apply('0, '0, '0, '0, '0);
        apply({32'h0, 32'h1, 32'h0, 32'hFFFFFFFF}, '0, '0, '0, '0);
        apply('0, '0, '0, '0, '1);
        apply({32'h0, 32'hFFFF0000, 64'h0}, {32'h0, 32'h00010000, 64'h0}, 128'h1, 128'h3, '0);
        apply('0, {32'h0, 32'h04000000, 64'h0}, 128'h2, '0, '1);
        ids();
        addrs();
        do_reset();
        tally_and_finish();
    end
    // cut a hang short
    initial begin
        #50us;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
